// *** usb_ep_pkg.sv ***
// Shared constants for the control and interrupt endpoint logic
package usb_ep_pkg;

  // ---------------------------------------------------------------
  // Register indices on the local register port
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_RX_CTRL   = 3'h0;
  localparam logic [2:0] ADDR_RX_STAT   = 3'h1;
  localparam logic [2:0] ADDR_RX_FLAGS  = 3'h2;
  localparam logic [2:0] ADDR_TX1_DATA  = 3'h3;
  localparam logic [2:0] ADDR_TX1_COUNT = 3'h4;
  localparam logic [2:0] ADDR_RX_DATA   = 3'h5;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_CLEAR_BIT = 7;
  localparam int CTRL_STALL_BIT = 3;
  localparam int CTRL_FEN_BIT   = 1;
  localparam int CTRL_EN_BIT    = 0;
  localparam int STAT_SEQ_BIT   = 7;
  localparam int STAT_SETUP_BIT = 6;
  localparam int STAT_ACK_BIT   = 0;
  localparam int COUNT_W        = 4;

  // ---------------------------------------------------------------
  // Reset values and sizes
  // ---------------------------------------------------------------
  localparam logic [7:0]         BYTE_ZERO   = 8'h00;
  localparam logic [3:0]         NIBBLE_ZERO = 4'h0;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 4'h0;
  localparam int                 FIFO_WIDTH  = 8;
  localparam int                 FIFO_DEPTH  = 32;

  // ---------------------------------------------------------------
  // Handshake codes toward the serial engine
  // ---------------------------------------------------------------
  localparam logic [1:0] HS_NONE  = 2'h0;
  localparam logic [1:0] HS_GO    = 2'h1;
  localparam logic [1:0] HS_NACK  = 2'h2;
  localparam logic [1:0] HS_STALL = 2'h3;

endpackage

// *** usb_ep0_rx_ep1_tx_load.sv ***
// Byte FIFO and control/interrupt endpoint register logic
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Byte FIFO with clear
// ---------------------------------------------------------------
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int PTR_W = $clog2(DEPTH)
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             clear_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out,
  output logic                  full_out,
  output logic                  empty_out
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   count;
  logic [PTR_W:0]   next_count;
  logic             push;
  logic             pop;

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    bump = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Handshakes; full and empty are flops so ready never glitches
  assign push          = in_valid_in & ~full_out;
  assign pop           = out_ready_in & ~empty_out;
  assign in_ready_out  = ~full_out;
  assign out_valid_out = ~empty_out;
  assign out_data_out  = mem[rd_ptr];

  // Occupancy after this cycle
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // Pointers and flags; clear beats any traffic in the same cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      full_out  <= 1'b0;
      empty_out <= 1'b1;
    end else if (clear_in) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      full_out  <= 1'b0;
      empty_out <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      count     <= next_count;
      full_out  <= (next_count == (PTR_W + 1)'(DEPTH));
      empty_out <= (next_count == '0);
    end
  end

  // Storage, no reset needed for data
  always_ff @(posedge clk_in) begin
    if (push && !clear_in) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
endmodule

// ---------------------------------------------------------------
// Endpoint logic
// ---------------------------------------------------------------
module usb_ep0_rx_ep1_tx_load (
  input  wire logic       sys_clk_in,
  input  wire logic       rstn_in,
  input  wire logic [2:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic       ctrl_tx_enable_in,
  input  wire logic       usb_setup_begin_in,
  input  wire logic       usb_setup_end_in,
  input  wire logic       usb_status_stage_in,
  input  wire logic       usb_rx_valid_in,
  input  wire logic [7:0] usb_rx_byte_in,
  input  wire logic       usb_out_end_in,
  input  wire logic       usb_out_error_in,
  input  wire logic       usb_out_pid_match_in,
  input  wire logic       usb_in_token_in,
  input  wire logic       usb_in_ack_in,
  input  wire logic       intr_tx_stall_in,
  input  wire logic       usb_tx_pop_in,
  output logic      [7:0] tx_byte_out,
  output logic            tx1_ready_out,
  output logic            rx_ready_out,
  output logic            rx_accept_out,
  output logic      [1:0] out_hs_out,
  output logic            out_hs_valid_out,
  output logic      [1:0] in_hs_out,
  output logic            in_hs_valid_out,
  output logic            connect_out,
  output logic            irq_out
);
  logic [1:0]  rst_pipe;
  logic        rst_n;
  logic        rx_clear;
  logic        rx_stall_req;
  logic        rx_fen;
  logic        rx_en;
  logic        seq;
  logic        setup;
  logic        fsw;
  logic        stat_seen;
  logic        st_stall;
  logic        st_nack;
  logic        st_err;
  logic        st_ack;
  logic        rx_underrun;
  logic        rx_overrun;
  logic [3:0]  count;
  logic        tx_armed;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_tx1;
  logic        wr_count;
  logic        rd_data;
  logic        clear_req;
  logic        rx_accept;
  logic [1:0]  out_pick;
  logic        ack_set;
  logic        rx_in_ready;
  logic        rx_out_valid;
  logic [7:0]  rx_out_data;
  logic        rx_full;
  logic        rx_empty;
  logic        tx_in_ready;
  logic        tx_out_valid;
  logic [7:0]  tx_out_data;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] idx);
    hit = (a == idx);
  endfunction

  // Stall outranks a missing enable on both endpoints
  function automatic logic [1:0] hs_pick(input logic ready, input logic stall);
    hs_pick = stall ? usb_ep_pkg::HS_STALL : (ready ? usb_ep_pkg::HS_GO : usb_ep_pkg::HS_NACK);
  endfunction

  // Reset release through two flops
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // Register port decode
  assign wr_ctrl   = reg_wr_in & hit(reg_addr_in, usb_ep_pkg::ADDR_RX_CTRL);
  assign wr_stat   = reg_wr_in & hit(reg_addr_in, usb_ep_pkg::ADDR_RX_STAT);
  assign wr_tx1    = reg_wr_in & hit(reg_addr_in, usb_ep_pkg::ADDR_TX1_DATA);
  assign wr_count  = reg_wr_in & hit(reg_addr_in, usb_ep_pkg::ADDR_TX1_COUNT);
  assign rd_data   = reg_rd_in & hit(reg_addr_in, usb_ep_pkg::ADDR_RX_DATA);
  assign clear_req = wr_ctrl & reg_wdata_in[usb_ep_pkg::CTRL_CLEAR_BIT];

  // Setup bytes always land; OUT bytes need enable and no stall
  assign rx_accept = fsw | (rx_fen & ~rx_stall_req);
  assign out_pick  = hs_pick(rx_fen, rx_stall_req);
  assign ack_set   = usb_out_end_in & ~usb_out_error_in & (out_pick == usb_ep_pkg::HS_GO);

  // ---------------------------------------------------------------
  // Receive control register
  // ---------------------------------------------------------------
  // Hardware clears come last so they beat a racing software write
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_clear     <= 1'b0;
      rx_stall_req <= 1'b0;
      rx_fen       <= 1'b0;
      rx_en        <= 1'b0;
    end else begin
      rx_clear <= clear_req;
      if (wr_ctrl) begin
        rx_en        <= reg_wdata_in[usb_ep_pkg::CTRL_EN_BIT];
        rx_stall_req <= reg_wdata_in[usb_ep_pkg::CTRL_STALL_BIT];
        rx_fen       <= reg_wdata_in[usb_ep_pkg::CTRL_FEN_BIT];
      end
      if (usb_setup_end_in) begin
        rx_stall_req <= 1'b0;
      end
      if (ack_set || usb_setup_end_in || clear_req) begin
        rx_fen <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive status register
  // ---------------------------------------------------------------
  // Software clears first, hardware sets after: a set in the clear cycle survives
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      seq      <= 1'b0;
      setup    <= 1'b0;
      fsw      <= 1'b0;
      stat_seen <= 1'b0;
      st_stall <= 1'b0;
      st_nack  <= 1'b0;
      st_err   <= 1'b0;
      st_ack   <= 1'b0;
    end else begin
      if (wr_stat && reg_wdata_in[usb_ep_pkg::STAT_SETUP_BIT]) begin
        setup <= 1'b0;
      end
      if (wr_stat && reg_wdata_in[usb_ep_pkg::STAT_ACK_BIT]) begin
        st_ack <= 1'b0;
      end
      if (usb_setup_begin_in) begin
        fsw    <= 1'b1;
        stat_seen <= 1'b0;
        st_ack <= 1'b0;
      end
      if (usb_setup_end_in) begin
        fsw   <= 1'b0;
        seq   <= 1'b1;
        setup <= 1'b1;
      end
      if (usb_status_stage_in) begin
        stat_seen <= 1'b1;
      end
      if (usb_out_end_in) begin
        st_err <= usb_out_error_in;
        if (!usb_out_error_in) begin
          st_stall <= (out_pick == usb_ep_pkg::HS_STALL);
          st_nack  <= (out_pick == usb_ep_pkg::HS_NACK);
          if (ack_set && usb_out_pid_match_in) begin
            seq <= ~seq;
          end
        end
      end
      if (ack_set) begin
        st_ack <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive FIFO and its error flags
  // ---------------------------------------------------------------
  // A new setup also flushes stale OUT data before overwriting
  byte_fifo #(
    .WIDTH (usb_ep_pkg::FIFO_WIDTH),
    .DEPTH (usb_ep_pkg::FIFO_DEPTH)
  ) rx_fifo (
    .clk_in        (sys_clk_in),
    .rst_n_in      (rst_n),
    .clear_in      (rx_clear | usb_setup_begin_in),
    .in_valid_in   (usb_rx_valid_in & rx_accept),
    .in_ready_out  (rx_in_ready),
    .in_data_in    (usb_rx_byte_in),
    .out_valid_out (rx_out_valid),
    .out_ready_in  (rd_data),
    .out_data_out  (rx_out_data),
    .full_out      (rx_full),
    .empty_out     (rx_empty)
  );

  // Sticky error flags; only a completed clear drops them
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_underrun <= 1'b0;
      rx_overrun  <= 1'b0;
    end else begin
      if (rx_clear) begin
        rx_underrun <= 1'b0;
        rx_overrun  <= 1'b0;
      end
      if (rd_data && !rx_out_valid) begin
        rx_underrun <= 1'b1;
      end
      if (usb_rx_valid_in && rx_accept && !rx_in_ready) begin
        rx_overrun <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt endpoint transmit load
  // ---------------------------------------------------------------
  // Bytes beyond a full FIFO are dropped; software watches tx1_ready_out
  byte_fifo #(
    .WIDTH (usb_ep_pkg::FIFO_WIDTH),
    .DEPTH (usb_ep_pkg::FIFO_DEPTH)
  ) tx_fifo (
    .clk_in        (sys_clk_in),
    .rst_n_in      (rst_n),
    .clear_in      (1'b0),
    .in_valid_in   (wr_tx1),
    .in_ready_out  (tx_in_ready),
    .in_data_in    (reg_wdata_in),
    .out_valid_out (tx_out_valid),
    .out_ready_in  (usb_tx_pop_in),
    .out_data_out  (tx_out_data),
    .full_out      (),
    .empty_out     ()
  );

  // Count never decrements; write arms, host ack disarms, arm wins
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      count   <= usb_ep_pkg::COUNT_RESET;
      tx_armed <= 1'b0;
    end else begin
      if (usb_in_ack_in) begin
        tx_armed <= 1'b0;
      end
      if (wr_count) begin
        count    <= reg_wdata_in[usb_ep_pkg::COUNT_W-1:0];
        tx_armed <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  // Handshakes, connect, interrupt and serial-side data
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      out_hs_out       <= usb_ep_pkg::HS_NONE;
      out_hs_valid_out <= 1'b0;
      in_hs_out        <= usb_ep_pkg::HS_NONE;
      in_hs_valid_out  <= 1'b0;
      connect_out      <= 1'b0;
      irq_out          <= 1'b0;
      tx_byte_out      <= usb_ep_pkg::BYTE_ZERO;
      tx1_ready_out    <= 1'b0;
      rx_ready_out     <= 1'b0;
      rx_accept_out    <= 1'b0;
    end else begin
      out_hs_valid_out <= usb_out_end_in;
      out_hs_out       <= usb_out_error_in ? usb_ep_pkg::HS_NONE : out_pick;
      in_hs_valid_out  <= usb_in_token_in;
      in_hs_out        <= hs_pick(tx_armed, intr_tx_stall_in);
      connect_out      <= rx_en & ctrl_tx_enable_in;
      irq_out          <= st_ack | rx_underrun | rx_overrun;
      tx1_ready_out    <= tx_in_ready;
      rx_ready_out     <= rx_in_ready;
      rx_accept_out    <= rx_accept;
      if (usb_tx_pop_in) begin
        tx_byte_out <= tx_out_valid ? tx_out_data : usb_ep_pkg::BYTE_ZERO;
      end
    end
  end

  // Register read-back, reserved bits zero
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out <= usb_ep_pkg::BYTE_ZERO;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        usb_ep_pkg::ADDR_RX_CTRL:   reg_rdata_out <= {rx_clear, 3'h0, rx_stall_req, 1'b0, rx_fen, rx_en};
        usb_ep_pkg::ADDR_RX_STAT:   reg_rdata_out <= {seq, setup, fsw, stat_seen, st_stall, st_nack, st_err, st_ack};
        usb_ep_pkg::ADDR_RX_FLAGS:  reg_rdata_out <= {usb_ep_pkg::NIBBLE_ZERO, rx_empty, rx_full,
                                                      rx_underrun, rx_overrun};
        usb_ep_pkg::ADDR_TX1_COUNT: reg_rdata_out <= {usb_ep_pkg::NIBBLE_ZERO, count};
        usb_ep_pkg::ADDR_RX_DATA:   reg_rdata_out <= rx_out_valid ? rx_out_data : usb_ep_pkg::BYTE_ZERO;
        default:                    reg_rdata_out <= usb_ep_pkg::BYTE_ZERO;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_clear_done;
    @(posedge sys_clk_in) disable iff (!rst_n)
      (clear_req && !usb_rx_valid_in && !reg_rd_in) |=> rx_clear ##1
        (!rx_clear && rx_empty && !rx_underrun && !rx_overrun);
  endproperty
  a_clear_done: assert property (p_clear_done) else $error("receive clear did not complete");

  property p_out_stall;
    @(posedge sys_clk_in) disable iff (!rst_n)
      (usb_out_end_in && !usb_out_error_in && rx_stall_req) |=> (out_hs_valid_out && out_hs_out == usb_ep_pkg::HS_STALL);
  endproperty
  a_out_stall: assert property (p_out_stall) else $error("stall request not answered with stall");

  property p_out_nack;
    @(posedge sys_clk_in) disable iff (!rst_n)
      (usb_out_end_in && !usb_out_error_in && !rx_stall_req && !rx_fen) |=> (out_hs_out == usb_ep_pkg::HS_NACK && st_nack);
  endproperty
  a_out_nack: assert property (p_out_nack) else $error("disabled OUT not answered with nack");

  property p_setup_accept;
    @(posedge sys_clk_in) disable iff (!rst_n)
      usb_setup_begin_in |=> fsw ##1 rx_accept_out;
  endproperty
  a_setup_accept: assert property (p_setup_accept) else $error("setup data not accepted");

  property p_setup_end;
    @(posedge sys_clk_in) disable iff (!rst_n)
      usb_setup_end_in |=> (!rx_stall_req && !rx_fen && seq && setup && !fsw);
  endproperty
  a_setup_end: assert property (p_setup_end) else $error("setup end effects missing");

  property p_connect;
    @(posedge sys_clk_in) disable iff (!rst_n)
      (!rx_en || !ctrl_tx_enable_in) |=> !connect_out;
  endproperty
  a_connect: assert property (p_connect) else $error("connected without both enables");

  property p_ack_fen;
    @(posedge sys_clk_in) disable iff (!rst_n)
      (ack_set && !usb_setup_begin_in) |=> (st_ack && !rx_fen) ##1 irq_out;
  endproperty
  a_ack_fen: assert property (p_ack_fen) else $error("ack did not set interrupt or drop enable");

  property p_underflow;
    @(posedge sys_clk_in) disable iff (!rst_n)
      (rd_data && !rx_out_valid && !rx_clear) |=> rx_underrun ##1 irq_out;
  endproperty
  a_underflow: assert property (p_underflow) else $error("empty read missed underflow");

  property p_count_arm;
    @(posedge sys_clk_in) disable iff (!rst_n)
      wr_count |=> (tx_armed && count == $past(reg_wdata_in[3:0]));
  endproperty
  a_count_arm: assert property (p_count_arm) else $error("count write did not arm transmit");

  property p_in_reply;
    @(posedge sys_clk_in) disable iff (!rst_n)
      (usb_in_token_in && !tx_armed && !intr_tx_stall_in) |=> (in_hs_valid_out && in_hs_out == usb_ep_pkg::HS_NACK);
  endproperty
  a_in_reply: assert property (p_in_reply) else $error("unarmed IN not answered with nack");
endmodule

// *** usb_host_model.sv ***
// Serial engine stand-in that fires USB events at the endpoint logic
`timescale 1ns/1ps
module usb_host_model (
  input  wire logic       clk_in,
  output logic            sbeg_out,
  output logic            send_out,
  output logic            stat_out,
  output logic            rxv_out,
  output logic      [7:0] rxb_out,
  output logic            oend_out,
  output logic            oerr_out,
  output logic            opid_out,
  output logic            itok_out,
  output logic            iack_out,
  output logic            pop_out
);
  // Idle levels from time zero
  initial begin
    {sbeg_out, send_out, stat_out, rxv_out, oend_out, oerr_out, opid_out, itok_out, iack_out, pop_out} = '0;
    rxb_out = 8'h00;
  end
  // One event per call, one edge wide; kinds: begin, end, status, byte, out end, in, in ack, pop
  task automatic fire(input int kind, input logic [7:0] b, input logic err, input logic pid);
    @(posedge clk_in);
    sbeg_out <= (kind == 0);
    send_out <= (kind == 1);
    stat_out <= (kind == 2);
    rxv_out  <= (kind == 3);
    rxb_out  <= b;
    oend_out <= (kind == 4);
    oerr_out <= err;
    opid_out <= pid;
    itok_out <= (kind == 5);
    iack_out <= (kind == 6);
    pop_out  <= (kind == 7);
    @(posedge clk_in);
    {sbeg_out, send_out, stat_out, rxv_out, oend_out, oerr_out, opid_out, itok_out, iack_out, pop_out} <= '0;
    rxb_out <= ~b; // Released lane never shows a stale byte
  endtask
endmodule

// *** usb_ep0_rx_ep1_tx_load_test.sv ***
// Self-checking bench for the control and interrupt endpoint logic
`timescale 1ns/1ps
module usb_ep0_rx_ep1_tx_load_test;
  logic       clk, rstn, wr_en, rd_en, tx0_en, tx1_stall;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, rxb, txb;
  logic       sbeg, send, stat, rxv, oend, oerr, opid, itok, iack, pop;
  logic       tx1_rdy, rx_rdy, rx_acc, ohs_v, ihs_v, conn, irq;
  logic [1:0] ohs, ihs;
  int         n_fail, tests_run, seed, i;
  logic [7:0] q[$];

  usb_ep0_rx_ep1_tx_load dut_u (.sys_clk_in(clk), .rstn_in(rstn), .reg_addr_in(addr), .reg_wr_in(wr_en),
    .reg_rd_in(rd_en), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .ctrl_tx_enable_in(tx0_en),
    .usb_setup_begin_in(sbeg), .usb_setup_end_in(send), .usb_status_stage_in(stat), .usb_rx_valid_in(rxv),
    .usb_rx_byte_in(rxb), .usb_out_end_in(oend), .usb_out_error_in(oerr), .usb_out_pid_match_in(opid),
    .usb_in_token_in(itok), .usb_in_ack_in(iack), .intr_tx_stall_in(tx1_stall), .usb_tx_pop_in(pop),
    .tx_byte_out(txb), .tx1_ready_out(tx1_rdy), .rx_ready_out(rx_rdy), .rx_accept_out(rx_acc),
    .out_hs_out(ohs), .out_hs_valid_out(ohs_v), .in_hs_out(ihs), .in_hs_valid_out(ihs_v),
    .connect_out(conn), .irq_out(irq));
  usb_host_model host_u (.clk_in(clk), .sbeg_out(sbeg), .send_out(send), .stat_out(stat), .rxv_out(rxv),
    .rxb_out(rxb), .oend_out(oend), .oerr_out(oerr), .opid_out(opid), .itok_out(itok), .iack_out(iack),
    .pop_out(pop));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // Read data lands on the same edge that takes the strobe
  task automatic rchk(input string nm, input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check(nm, rdata, exp);
  endtask
  // Handshake pulse is looked at in its single valid cycle
  task automatic hs_chk(input logic outp, input logic [1:0] exp);
    #1;
    check(outp ? "out hs" : "in hs", outp ? {5'h0, ohs_v, ohs} : {5'h0, ihs_v, ihs}, {5'h0, 1'b1, exp});
  endtask
  // Reference queue mirrors every byte handed to the receive path
  task automatic send_byte();
    logic [7:0] b;
    b = 8'($random(seed));
    q.push_back(b);
    host_u.fire(3, b, 1'b0, 1'b0);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h8bd4;
    n_fail = 0;
    tests_run = 0;
    {rstn, wr_en, rd_en, tx0_en, tx1_stall} = '0;
    addr = 3'h0;
    wdata = 8'h00;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rchk("flags", 3'h2, 8'h08);
    rchk("status", 3'h1, 8'h00);
    wr(3'h0, 8'h01);
    repeat (2) @(posedge clk);
    #1 check("connect", 8'(conn), 8'h00);
    @(posedge clk);
    tx0_en <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check("connect", 8'(conn), 8'h01);
    host_u.fire(4, 8'h00, 1'b0, 1'b1);
    hs_chk(1'b1, 2'h2);
    wr(3'h0, 8'h0b);
    host_u.fire(4, 8'h00, 1'b0, 1'b1);
    hs_chk(1'b1, 2'h3);
    rchk("status", 3'h1, 8'h08);
    check("rx accept", 8'(rx_acc), 8'h00);
    // Setup taken while stall and enable are both up
    host_u.fire(0, 8'h00, 1'b0, 1'b0);
    rchk("status", 3'h1, 8'h28);
    check("rx accept", 8'(rx_acc), 8'h01);
    for (i = 0; i < 8; i++) send_byte();
    host_u.fire(1, 8'h00, 1'b0, 1'b0);
    rchk("control", 3'h0, 8'h01);
    rchk("status", 3'h1, 8'hc8);
    wr(3'h1, 8'h40);
    rchk("status", 3'h1, 8'h88);
    for (i = 0; i < 8; i++) rchk("rx data", 3'h5, q.pop_front());
    rchk("rx data", 3'h5, 8'h00);
    rchk("flags", 3'h2, 8'h0a);
    check("irq", 8'(irq), 8'h01);
    wr(3'h0, 8'h81);
    rchk("control", 3'h0, 8'h01);
    rchk("flags", 3'h2, 8'h08);
    check("irq", 8'(irq), 8'h00);
    // Data stage accepted and acknowledged
    wr(3'h0, 8'h03);
    for (i = 0; i < 4; i++) send_byte();
    host_u.fire(4, 8'h00, 1'b0, 1'b1);
    hs_chk(1'b1, 2'h1);
    rchk("control", 3'h0, 8'h01);
    rchk("status", 3'h1, 8'h01);
    check("irq", 8'(irq), 8'h01);
    for (i = 0; i < 4; i++) rchk("rx data", 3'h5, q.pop_front());
    host_u.fire(2, 8'h00, 1'b0, 1'b0);
    rchk("status", 3'h1, 8'h11);
    host_u.fire(4, 8'h00, 1'b1, 1'b0);
    rchk("status", 3'h1, 8'h13);
    host_u.fire(0, 8'h00, 1'b0, 1'b0);
    rchk("status", 3'h1, 8'h22);
    // One byte more than the FIFO holds
    for (i = 0; i < 33; i++) send_byte();
    rchk("flags", 3'h2, 8'h05);
    check("rx ready", 8'(rx_rdy), 8'h00);
    check("irq", 8'(irq), 8'h01);
    host_u.fire(1, 8'h00, 1'b0, 1'b0);
    wr(3'h0, 8'h81);
    rchk("flags", 3'h2, 8'h08);
    // Interrupt endpoint load and send
    q.delete();
    for (i = 0; i < 5; i++) begin
      q.push_back(8'($random(seed)));
      wr(3'h3, q[i]);
    end
    check("tx ready", 8'(tx1_rdy), 8'h01);
    wr(3'h4, 8'h05);
    rchk("byte count", 3'h4, 8'h05);
    host_u.fire(5, 8'h00, 1'b0, 1'b0);
    hs_chk(1'b0, 2'h1);
    for (i = 0; i < 5; i++) begin
      host_u.fire(7, 8'h00, 1'b0, 1'b0);
      #1 check("tx byte", txb, q[i]);
    end
    host_u.fire(6, 8'h00, 1'b0, 1'b0);
    rchk("byte count", 3'h4, 8'h05);
    host_u.fire(5, 8'h00, 1'b0, 1'b0);
    hs_chk(1'b0, 2'h2);
    @(posedge clk);
    tx1_stall <= 1'b1;
    host_u.fire(5, 8'h00, 1'b0, 1'b0);
    hs_chk(1'b0, 2'h3);
    give_verdict();
  end
endmodule
